// >>> inc/ata_cmd_pkg.sv
package ata_cmd_pkg;
	// Command opcodes and download subcommands
	localparam logic [7:0] OP_DL_DMA  = 8'h93;
	localparam logic [7:0] OP_DIAG    = 8'h90;
	localparam logic [7:0] OP_FLUSH   = 8'he7;
	localparam logic [7:0] SUB_OFFSET = 8'h03;
	localparam logic [7:0] SUB_WHOLE  = 8'h07;
	// Completion flag bit positions
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	// Error flag bit positions
	localparam int ER_UNC = 6;
	localparam int ER_ABT = 2;
	// Flag values after reset and at rest
	localparam logic [7:0] STATUS_IDLE = 8'h50;
	localparam logic [7:0] ERROR_NONE  = 8'h00;
	// One 512-byte sector is 128 dwords
	localparam int SECT_SHIFT = 7;
	localparam int WADDR_W    = 23;
	// Bit of image dword 0 that asks for a reload
	localparam int RELOAD_BIT = 0;
	// Host register map, byte addresses
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] A_CMD    = 5'h00;
	localparam logic [ADDR_W-1:0] A_PARAM  = 5'h04;
	localparam logic [ADDR_W-1:0] A_DATA   = 5'h08;
	localparam logic [ADDR_W-1:0] A_STATUS = 5'h0c;
	localparam logic [ADDR_W-1:0] A_CTRL   = 5'h10;
	localparam int CTRL_SRST_BIT = 0;
	localparam int STAT_DONE_BIT = 16;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Device sequencer states, Gray along idle-xfer-save
	typedef enum logic [2:0] {
		DS_IDLE  = 3'b000,
		DS_XFER  = 3'b001,
		DS_SAVE  = 3'b011,
		DS_DIAG  = 3'b010,
		DS_FLUSH = 3'b100
	} dev_state_e;
endpackage

// >>> inc/ata_link_if.sv
`timescale 1ns/100ps
interface ata_link_if;
	// Command block, host to device
	logic       cmd_valid;
	logic [7:0] cmd_opcode;
	logic [7:0] cmd_feature;
	logic [7:0] cmd_sec_cnt;
	logic [7:0] cmd_sec_num;
	logic [7:0] cmd_cyl_lo;
	logic [7:0] cmd_cyl_hi;
	logic       soft_reset;
	// DMA data phase
	logic        dma_valid;
	logic [31:0] dma_data;
	logic        dma_ready;
	// Device answers
	logic [7:0] status;
	logic [7:0] error;
	logic       cmd_done;

	modport dev (
		input  cmd_valid, cmd_opcode, cmd_feature, cmd_sec_cnt, cmd_sec_num,
		input  cmd_cyl_lo, cmd_cyl_hi, soft_reset, dma_valid, dma_data,
		output dma_ready, status, error, cmd_done
	);
	modport host (
		output cmd_valid, cmd_opcode, cmd_feature, cmd_sec_cnt, cmd_sec_num,
		output cmd_cyl_lo, cmd_cyl_hi, soft_reset, dma_valid, dma_data,
		input  dma_ready, status, error, cmd_done
	);
endinterface

// >>> rtl/xfer_counter.sv
`timescale 1ns/100ps
module xfer_counter (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           srst_i,
	// Control
	input  wire logic                           load_i,
	input  wire logic [15:0]                    sectors_i,
	input  wire logic                           beat_i,
	// State
	output logic                                last_o,
	output logic [ata_cmd_pkg::WADDR_W-1:0]     index_o
);
	import ata_cmd_pkg::*;

	logic [WADDR_W-1:0] remain_reg;   // Dwords still to come
	logic [WADDR_W-1:0] index_reg;    // Dwords already taken

	// Whole sectors only, so length is sectors times 128 dwords
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			remain_reg <= '0;
			index_reg  <= '0;
		end else if (load_i) begin
			remain_reg <= WADDR_W'({sectors_i, 7'h00});
			index_reg  <= '0;
		end else if (beat_i && remain_reg != '0) begin
			remain_reg <= remain_reg - WADDR_W'(1);
			index_reg  <= index_reg + WADDR_W'(1);
		end
	end

	assign last_o  = (remain_reg == WADDR_W'(1));
	assign index_o = index_reg;
endmodule // xfer_counter

// >>> rtl/ata_dev_end.sv
`timescale 1ns/100ps
module ata_dev_end (
	// Clock and reset
	input  wire logic                           CORE_CLK_I,
	input  wire logic                           SRST_I,
	// Link to host controller
	ata_link_if.dev                             LINK,
	// Drive state
	input  wire logic                           SECURITY_LOCKED_I,
	input  wire logic                           SPINUP_DISABLED_I,
	input  wire logic [15:0]                    IMAGE_SECTORS_I,
	// Image store
	output logic                                IMG_VALID_O,
	output logic [ata_cmd_pkg::WADDR_W-1:0]     IMG_ADDR_O,
	output logic [31:0]                         IMG_DATA_O,
	output logic                                SAVE_REQ_O,
	input  wire logic                           SAVE_DONE_I,
	input  wire logic                           RELOAD_FAIL_I,
	output logic                                ACTIVATE_O,
	output logic                                SPIN_DOWN_O,
	output logic                                DISCARD_O,
	// Diagnostics and cache
	output logic                                DIAG_REQ_O,
	input  wire logic                           DIAG_DONE_I,
	input  wire logic [7:0]                     DIAG_CODE_I,
	output logic                                FLUSH_REQ_O,
	input  wire logic                           FLUSH_DONE_I
);
	import ata_cmd_pkg::*;

	dev_state_e         state_reg;      // Sequencer state
	dev_state_e         state_next;     // Its next value
	logic [7:0]         status_reg;     // Completion flags seen by host
	logic [7:0]         error_reg;      // Error flags or diagnostic code
	logic               done_reg;       // One-cycle completion pulse
	logic               ready_reg;      // DMA ready
	logic [15:0]        expect_reg;     // Next offset expected, in sectors
	logic               partial_reg;    // Segments held, image incomplete
	logic               final_reg;      // Current segment ends the image
	logic               reload_reg;     // Image asks for reload
	logic [WADDR_W-1:0] base_reg;       // Dword address of segment start
	logic [15:0]        next_off_reg;   // Offset after current segment
	logic               img_valid_reg;
	logic [WADDR_W-1:0] img_addr_reg;
	logic [31:0]        img_data_reg;
	logic               activate_reg;
	logic               spin_down_reg;
	logic               discard_reg;

	logic [15:0]        sectors;        // Requested length
	logic [15:0]        offset;         // Requested image offset
	logic [16:0]        seg_end;        // Offset plus length
	logic               beat;           // DMA dword taken
	logic               cnt_last;
	logic [WADDR_W-1:0] cnt_index;
	logic               start_xfer;
	logic               fin;            // Command ends this cycle
	logic               fin_err;        // Ends with ERR set
	logic [7:0]         err_next;       // Error value it ends with
	logic               drop;           // Discard held segments
	logic               seg_done;       // Non-final segment stored

	assign sectors = {LINK.cmd_sec_num, LINK.cmd_sec_cnt};
	assign offset  = {LINK.cmd_cyl_hi, LINK.cmd_cyl_lo};
	assign seg_end = {1'b0, offset} + {1'b0, sectors};
	assign beat    = LINK.dma_valid && ready_reg;

	// Word counter for the data phase
	xfer_counter u_cnt (
		.clk_i     (CORE_CLK_I),
		.srst_i    (SRST_I),
		.load_i    (start_xfer),
		.sectors_i (sectors),
		.beat_i    (beat),
		.last_o    (cnt_last),
		.index_o   (cnt_index)
	);

	// Command decode and sequencing
	always_comb begin
		state_next = state_reg;
		start_xfer = 1'b0;
		fin        = 1'b0;
		fin_err    = 1'b0;
		err_next   = ERROR_NONE;
		drop       = 1'b0;
		seg_done   = 1'b0;
		unique case (state_reg)
			DS_IDLE: begin
				if (LINK.cmd_valid) begin
					if (LINK.cmd_opcode == OP_DL_DMA) begin
						if ((LINK.cmd_feature != SUB_OFFSET && LINK.cmd_feature != SUB_WHOLE)
								|| SECURITY_LOCKED_I) begin
							fin              = 1'b1;
							fin_err          = 1'b1;
							err_next[ER_ABT] = 1'b1;
						end else if (LINK.cmd_feature == SUB_OFFSET && offset != expect_reg) begin
							// Out of sequence: abort and forget what came before
							fin              = 1'b1;
							fin_err          = 1'b1;
							err_next[ER_ABT] = 1'b1;
							drop             = 1'b1;
						end else if (sectors == 16'h0000) begin
							fin = 1'b1;
						end else begin
							start_xfer = 1'b1;
							state_next = DS_XFER;
						end
					end else if (LINK.cmd_opcode == OP_DIAG) begin
						drop       = 1'b1;
						state_next = DS_DIAG;
					end else if (LINK.cmd_opcode == OP_FLUSH) begin
						drop       = 1'b1;
						state_next = DS_FLUSH;
					end else begin
						// Not handled here: abort, still drops the partial image
						drop             = 1'b1;
						fin              = 1'b1;
						fin_err          = 1'b1;
						err_next[ER_ABT] = 1'b1;
					end
				end
			end
			DS_XFER: begin
				if (beat && cnt_last) begin
					if (final_reg) begin
						state_next = DS_SAVE;
					end else begin
						seg_done   = 1'b1;
						fin        = 1'b1;
						state_next = DS_IDLE;
					end
				end
			end
			DS_SAVE: begin
				// Store side verifies and saves, then reports reload result
				if (SAVE_DONE_I) begin
					fin              = 1'b1;
					fin_err          = reload_reg && RELOAD_FAIL_I;
					err_next[ER_UNC] = reload_reg && RELOAD_FAIL_I;
					drop             = 1'b1;
					state_next       = DS_IDLE;
				end
			end
			DS_DIAG: begin
				if (DIAG_DONE_I) begin
					fin        = 1'b1;
					err_next   = DIAG_CODE_I;
					state_next = DS_IDLE;
				end
			end
			DS_FLUSH: begin
				// Good status only once write-back is complete
				if (FLUSH_DONE_I) begin
					fin        = 1'b1;
					state_next = DS_IDLE;
				end
			end
			default: state_next = DS_IDLE;
		endcase
	end

	// Sequencer state; soft reset abandons any command
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset) begin
			state_reg <= DS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Completion and error flags, busy while a command runs
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset) begin
			status_reg <= STATUS_IDLE;
			error_reg  <= ERROR_NONE;
			done_reg   <= 1'b0;
		end else if (fin) begin
			status_reg         <= STATUS_IDLE;
			status_reg[ST_ERR] <= fin_err;
			error_reg          <= err_next;
			done_reg           <= 1'b1;
		end else begin
			done_reg <= 1'b0;
			if (state_next != DS_IDLE) begin
				// BSY through data phase, verify and save, diagnostic and flush
				status_reg         <= 8'h00;
				status_reg[ST_BSY] <= 1'b1;
				status_reg[ST_DRQ] <= (state_next == DS_XFER);
			end
		end
	end

	// DMA ready follows the next state so the last dword closes it
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= (state_next == DS_XFER);
		end
	end

	// Segment bookkeeping
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset || drop) begin
			// Held segments are thrown away; next download must start at 0
			expect_reg  <= 16'h0000;
			partial_reg <= 1'b0;
		end else if (seg_done) begin
			expect_reg  <= next_off_reg;
			partial_reg <= 1'b1;
		end
		if (SRST_I) begin
			final_reg    <= 1'b0;
			base_reg     <= '0;
			next_off_reg <= 16'h0000;
		end else if (start_xfer) begin
			if (LINK.cmd_feature == SUB_WHOLE) begin
				final_reg <= 1'b1;
				base_reg  <= '0;
			end else begin
				// Segment that reaches the image size is the last one
				final_reg <= (seg_end >= {1'b0, IMAGE_SECTORS_I});
				base_reg  <= WADDR_W'({offset, 7'h00});
			end
			next_off_reg <= seg_end[15:0];
		end
	end

	// Reload request travels in dword 0 of the image
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset || drop) begin
			reload_reg <= 1'b0;
		end else if (beat && (base_reg + cnt_index) == '0) begin
			reload_reg <= LINK.dma_data[RELOAD_BIT];
		end
	end

	// Image store write port
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			img_valid_reg <= 1'b0;
			img_addr_reg  <= '0;
			img_data_reg  <= 32'h0000_0000;
		end else begin
			img_valid_reg <= beat;
			if (beat) begin
				img_addr_reg <= base_reg + cnt_index;
				img_data_reg <= LINK.dma_data;
			end
		end
	end

	// Side effects: activate, spin down, discard
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			activate_reg  <= 1'b0;
			spin_down_reg <= 1'b0;
			discard_reg   <= 1'b0;
		end else begin
			// Reload right after the saved image is complete
			activate_reg  <= (state_reg == DS_SAVE) && SAVE_DONE_I && reload_reg;
			spin_down_reg <= (state_reg == DS_SAVE) && SAVE_DONE_I && reload_reg
				&& !RELOAD_FAIL_I && SPINUP_DISABLED_I;
			// Tell the store its partial contents are dead
			discard_reg   <= (partial_reg || state_reg == DS_XFER)
				&& (drop || LINK.soft_reset) && state_reg != DS_SAVE;
		end
	end

	// Diagnostic, flush and save requests, held until answered
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I || LINK.soft_reset) begin
			DIAG_REQ_O  <= 1'b0;
			FLUSH_REQ_O <= 1'b0;
			SAVE_REQ_O  <= 1'b0;
		end else begin
			DIAG_REQ_O  <= (state_next == DS_DIAG);
			FLUSH_REQ_O <= (state_next == DS_FLUSH);
			SAVE_REQ_O  <= (state_next == DS_SAVE);
		end
	end

	assign LINK.status    = status_reg;
	assign LINK.error     = error_reg;
	assign LINK.cmd_done  = done_reg;
	assign LINK.dma_ready = ready_reg;
	assign IMG_VALID_O    = img_valid_reg;
	assign IMG_ADDR_O     = img_addr_reg;
	assign IMG_DATA_O     = img_data_reg;
	assign ACTIVATE_O     = activate_reg;
	assign SPIN_DOWN_O    = spin_down_reg;
	assign DISCARD_O      = discard_reg;
endmodule // ata_dev_end

// >>> rtl/ata_host_end.sv
`timescale 1ns/100ps
module ata_host_end (
	// Clock and reset
	input  wire logic                          CORE_CLK_I,
	input  wire logic                          SRST_I,
	// Link to drive
	ata_link_if.host                           LINK,
	// AXI4-Lite write address
	input  wire logic                          AWVALID_I,
	output logic                               AWREADY_O,
	input  wire logic [ata_cmd_pkg::ADDR_W-1:0] AWADDR_I,
	// AXI4-Lite write data
	input  wire logic                          WVALID_I,
	output logic                               WREADY_O,
	input  wire logic [31:0]                   WDATA_I,
	input  wire logic [3:0]                    WSTRB_I,
	// AXI4-Lite write response
	output logic                               BVALID_O,
	input  wire logic                          BREADY_I,
	output logic [1:0]                         BRESP_O,
	// AXI4-Lite read
	input  wire logic                          ARVALID_I,
	output logic                               ARREADY_O,
	input  wire logic [ata_cmd_pkg::ADDR_W-1:0] ARADDR_I,
	output logic                               RVALID_O,
	input  wire logic                          RREADY_I,
	output logic [31:0]                        RDATA_O,
	output logic [1:0]                         RRESP_O
);
	import ata_cmd_pkg::*;

	logic [ADDR_W-1:0] awaddr_reg;   // Held write address
	logic [31:0]       wdata_reg;    // Held write data
	logic [3:0]        wstrb_reg;
	logic [15:0]       cmd_reg;      // Feature and opcode
	logic [31:0]       param_reg;    // Offset and length
	logic              done_seen_reg;// Completion seen since last command
	logic              cmd_pulse_reg;
	logic              srst_pulse_reg;
	logic              dma_valid_reg;
	logic [31:0]       dma_data_reg;
	logic              both_held;    // Address and data both in
	logic              wr_cmd;       // Command write accepted
	logic [31:0]       wmerge;       // Lane-merged write value

	assign both_held = !AWREADY_O && !WREADY_O && !BVALID_O;
	// Busy drive refuses a new command
	assign wr_cmd    = both_held && awaddr_reg == A_CMD && !LINK.status[ST_BSY];

	// Byte lanes of the write
	always_comb begin
		wmerge = (awaddr_reg == A_PARAM) ? param_reg : {16'h0000, cmd_reg};
		for (int b = 0; b < 4; b++) begin
			if (wstrb_reg[b]) begin
				wmerge[b*8 +: 8] = wdata_reg[b*8 +: 8];
			end
		end
	end

	// Write address and data capture, in either order
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			AWREADY_O  <= 1'b1;
			WREADY_O   <= 1'b1;
			awaddr_reg <= '0;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
		end else if (BVALID_O && BREADY_I) begin
			AWREADY_O <= 1'b1;
			WREADY_O  <= 1'b1;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				AWREADY_O  <= 1'b0;
				awaddr_reg <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O) begin
				WREADY_O  <= 1'b0;
				wdata_reg <= WDATA_I;
				wstrb_reg <= WSTRB_I;
			end
		end
	end

	// Write action and response; a data write waits for the drive
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			BVALID_O      <= 1'b0;
			BRESP_O       <= RESP_OKAY;
			dma_valid_reg <= 1'b0;
			dma_data_reg  <= 32'h0000_0000;
		end else if (BVALID_O) begin
			if (BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end else if (both_held) begin
			if (awaddr_reg == A_DATA) begin
				if (!dma_valid_reg) begin
					dma_valid_reg <= 1'b1;
					dma_data_reg  <= wdata_reg;
				end else if (LINK.dma_ready) begin
					dma_valid_reg <= 1'b0;
					BVALID_O      <= 1'b1;
					BRESP_O       <= RESP_OKAY;
				end
			end else begin
				BVALID_O <= 1'b1;
				BRESP_O  <= (awaddr_reg == A_PARAM || awaddr_reg == A_CTRL || wr_cmd)
					? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Command block registers and strobes
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			cmd_reg        <= 16'h0000;
			param_reg      <= 32'h0000_0000;
			cmd_pulse_reg  <= 1'b0;
			srst_pulse_reg <= 1'b0;
		end else begin
			cmd_pulse_reg  <= wr_cmd;
			srst_pulse_reg <= both_held && awaddr_reg == A_CTRL
				&& wstrb_reg[0] && wdata_reg[CTRL_SRST_BIT];
			if (wr_cmd) begin
				cmd_reg <= wmerge[15:0];
			end
			if (both_held && awaddr_reg == A_PARAM) begin
				param_reg <= wmerge;
			end
		end
	end

	// Completion seen; a new completion wins over the clear
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			done_seen_reg <= 1'b0;
		end else if (LINK.cmd_done) begin
			done_seen_reg <= 1'b1;
		end else if (wr_cmd) begin
			done_seen_reg <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ARREADY_O <= 1'b1;
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h0000_0000;
			RRESP_O   <= RESP_OKAY;
		end else if (RVALID_O) begin
			if (RREADY_I) begin
				RVALID_O  <= 1'b0;
				ARREADY_O <= 1'b1;
			end
		end else if (ARVALID_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b1;
			RRESP_O   <= RESP_OKAY;
			unique case (ARADDR_I)
				A_CMD:    RDATA_O <= {16'h0000, cmd_reg};
				A_PARAM:  RDATA_O <= param_reg;
				A_STATUS: RDATA_O <= {15'h0000, done_seen_reg, LINK.error, LINK.status};
				A_DATA,
				A_CTRL:   RDATA_O <= 32'h0000_0000;
				default: begin
					RDATA_O <= 32'h0000_0000;
					RRESP_O <= RESP_SLVERR;
				end
			endcase
		end
	end

	assign LINK.cmd_valid   = cmd_pulse_reg;
	assign LINK.cmd_opcode  = cmd_reg[7:0];
	assign LINK.cmd_feature = cmd_reg[15:8];
	assign LINK.cmd_sec_cnt = param_reg[7:0];
	assign LINK.cmd_sec_num = param_reg[15:8];
	assign LINK.cmd_cyl_lo  = param_reg[23:16];
	assign LINK.cmd_cyl_hi  = param_reg[31:24];
	assign LINK.soft_reset  = srst_pulse_reg;
	assign LINK.dma_valid   = dma_valid_reg;
	assign LINK.dma_data    = dma_data_reg;
endmodule // ata_host_end

// >>> verification/ata_link_monitor.sv
`timescale 1ns/100ps
module ata_link_monitor
	import ata_cmd_pkg::*;
(
	// Clock and reset
	input  wire logic       CORE_CLK_I,
	input  wire logic       SRST_I,
	// Link, watched only
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_opcode,
	input  wire logic [7:0] cmd_feature,
	input  wire logic [7:0] cmd_sec_cnt,
	input  wire logic [7:0] cmd_sec_num,
	input  wire logic       soft_reset,
	input  wire logic       dma_ready,
	input  wire logic [7:0] status,
	input  wire logic [7:0] error,
	input  wire logic       cmd_done
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SRST_I);
	// Command taken by an idle drive
	wire logic        go  = cmd_valid && !status[ST_BSY];
	wire logic        dl  = go && cmd_opcode == OP_DL_DMA;
	wire logic [15:0] len = {cmd_sec_num, cmd_sec_cnt};
	// Busy first, then good final status
	sequence s_busy_to_idle;
		status[ST_BSY] ##[1:200] (cmd_done && status == STATUS_IDLE);
	endsequence
	property p_start;
		dl && cmd_feature == SUB_WHOLE && len != 16'h0 |=> dma_ready || (cmd_done && error[ER_ABT]);
	endproperty
	property p_bad;
		dl && cmd_feature != SUB_OFFSET && cmd_feature != SUB_WHOLE
			|=> cmd_done && status == 8'h51 && error[ER_ABT];
	endproperty
	property p_zero;
		dl && len == 16'h0 |=> cmd_done && !dma_ready;
	endproperty
	property p_diag;
		go && cmd_opcode == OP_DIAG |=> s_busy_to_idle;
	endproperty
	property p_flush;
		go && cmd_opcode == OP_FLUSH |=> s_busy_to_idle;
	endproperty
	property p_pulse;
		cmd_done |=> !cmd_done;
	endproperty
	property p_dma;
		dma_ready |-> status[ST_BSY] && status[ST_DRQ];
	endproperty
	property p_srst;
		soft_reset |=> status == STATUS_IDLE && error == ERROR_NONE && !dma_ready;
	endproperty
	a_start: assert property (p_start) else $error("download start");
	a_bad: assert property (p_bad) else $error("bad feature");
	a_zero: assert property (p_zero) else $error("zero length");
	a_diag: assert property (p_diag) else $error("diagnostic");
	a_flush: assert property (p_flush) else $error("flush");
	a_pulse: assert property (p_pulse) else $error("done width");
	a_dma: assert property (p_dma) else $error("data phase status");
	a_srst: assert property (p_srst) else $error("soft reset");
endmodule // ata_link_monitor

// >>> verification/test_disk_microcode_diag_flush_cmds.sv
`timescale 1ns/100ps
module test_disk_microcode_diag_flush_cmds;
	import ata_cmd_pkg::*;
	// Case: command, {lock,fail,nospin,reload}, {error,status}, moves data, spins down
	typedef struct packed {
		logic [7:0]  op;
		logic [7:0]  ft;
		logic [15:0] len;
		logic [15:0] off;
		logic [3:0]  cfg;
		logic [15:0] ex;
		logic        mv;
		logic        sp;
	} row_s;
	localparam row_s SEG0 = '{8'h93, 8'h03, 16'h1, 16'h0, 4'h0, 16'h0050, 1'h1, 1'h0};
	// Ordinary cases
	row_s rows [11] = '{
		'{8'h93, 8'h07, 16'h2, 16'h0, 4'h0, 16'h0050, 1'h1, 1'h0},
		'{8'h93, 8'h07, 16'h1, 16'h0, 4'h5, 16'h4051, 1'h1, 1'h0},
		'{8'h93, 8'h07, 16'h1, 16'h0, 4'h3, 16'h0050, 1'h1, 1'h1},
		'{8'h93, 8'h07, 16'h1, 16'h0, 4'h4, 16'h0050, 1'h1, 1'h0},
		'{8'h93, 8'h05, 16'h1, 16'h0, 4'h0, 16'h0451, 1'h0, 1'h0},
		'{8'h93, 8'h07, 16'h1, 16'h0, 4'h8, 16'h0451, 1'h0, 1'h0},
		'{8'h93, 8'h07, 16'h0, 16'h0, 4'h0, 16'h0050, 1'h0, 1'h0},
		'{8'h90, 8'h00, 16'h0, 16'h0, 4'h0, 16'h3c50, 1'h0, 1'h0},
		'{8'he7, 8'h00, 16'h0, 16'h0, 4'h0, 16'h0050, 1'h0, 1'h0},
		SEG0,
		'{8'h93, 8'h03, 16'h1, 16'h1, 4'h0, 16'h0050, 1'h1, 1'h0}};
	logic        clk = 1'h0, srst = 1'h1;
	logic        awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic [4:0]  awa = 5'h0, ara = 5'h0;
	logic [31:0] wd = 32'h0, s;
	logic        lock = 1'h0, fail = 1'h0, nosp = 1'h0;
	logic        sdone = 1'h0, ddone = 1'h0, fdone = 1'h0;
	logic        disc, spun, actd;
	logic [22:0] first_addr;
	logic [31:0] last_data;     // Last dword the store was handed
	logic [1:0]  q;
	int          beats, mismatches = 0, samples_checked = 0;
	wire logic        awr, wrd, bv, arr, rv, iv, sreq, act, spd, dsc, dreq, freq;
	wire logic [1:0]  bre, rre;
	wire logic [31:0] rdat, idat;
	wire logic [22:0] iad;
	ata_link_if link ();
	ata_host_end ata_host_end_inst (.CORE_CLK_I(clk), .SRST_I(srst), .LINK(link),
		.AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv), .WREADY_O(wrd),
		.WDATA_I(wd), .WSTRB_I(4'hf), .BVALID_O(bv), .BREADY_I(br), .BRESP_O(bre),
		.ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rr),
		.RDATA_O(rdat), .RRESP_O(rre));
	ata_dev_end ata_dev_end_inst (.CORE_CLK_I(clk), .SRST_I(srst), .LINK(link),
		.SECURITY_LOCKED_I(lock), .SPINUP_DISABLED_I(nosp), .IMAGE_SECTORS_I(16'h2),
		.IMG_VALID_O(iv), .IMG_ADDR_O(iad), .IMG_DATA_O(idat), .SAVE_REQ_O(sreq),
		.SAVE_DONE_I(sdone), .RELOAD_FAIL_I(fail), .ACTIVATE_O(act), .SPIN_DOWN_O(spd),
		.DISCARD_O(dsc), .DIAG_REQ_O(dreq), .DIAG_DONE_I(ddone), .DIAG_CODE_I(8'h3c),
		.FLUSH_REQ_O(freq), .FLUSH_DONE_I(fdone));
	ata_link_monitor ata_link_monitor_inst (.CORE_CLK_I(clk), .SRST_I(srst),
		.cmd_valid(link.cmd_valid), .cmd_opcode(link.cmd_opcode),
		.cmd_feature(link.cmd_feature), .cmd_sec_cnt(link.cmd_sec_cnt),
		.cmd_sec_num(link.cmd_sec_num), .soft_reset(link.soft_reset),
		.dma_ready(link.dma_ready), .status(link.status), .error(link.error),
		.cmd_done(link.cmd_done));
	always #2 clk = ~clk;
	// Media side answers each request one cycle late; image writes and pulses logged
	always @(posedge clk) begin
		sdone <= sreq && !sdone;
		ddone <= dreq && !ddone;
		fdone <= freq && !fdone;
		if (iv && beats == 0) first_addr <= iad;
		if (iv) beats <= beats + 1;
		if (iv) last_data <= idat;
		if (dsc) disc <= 1'h1;
		if (spd) spun <= 1'h1;
		if (act) actd <= 1'h1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One write; ready sampled mid-cycle, stable until the next edge
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rsp);
		logic ta, tw, tb;
		@(posedge clk);
		{awv, wv, br, awa, wd} <= {3'h7, a, d};
		do begin
			@(negedge clk);
			{ta, tw, tb, rsp} = {awv && awr, wv && wrd, bv, bre};
			@(posedge clk);
			if (ta) awv <= 1'h0;
			if (tw) wv <= 1'h0;
		end while (!tb);
		br <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rsp);
		logic ta, tr;
		@(posedge clk);
		{arv, rr, ara} <= {2'h3, a};
		do begin
			@(negedge clk);
			{ta, tr, d, rsp} = {arv && arr, rv, rdat, rre};
			@(posedge clk);
			if (ta) arv <= 1'h0;
		end while (!tr);
		rr <= 1'h0;
	endtask
	// Issue a command, feed its data, wait for done and check the outcome
	task automatic run(input row_s r);
		{beats, disc, spun, actd} = 35'h0;
		{lock, fail, nosp} <= r.cfg[3:1];
		wr(A_PARAM, {r.off, r.len}, q);
		wr(A_CMD, {16'h0, r.ft, r.op}, q);
		if (r.mv) for (int i = 0; i < (r.len << SECT_SHIFT); i++) wr(A_DATA, (i == 0) ? {31'h0, r.cfg[0]} : 32'(i), q);
		s = 32'h0;
		while (!s[16]) rd(A_STATUS, s, q);
		chk("status", {15'h0, 1'h1, r.ex}, s);
		chk("beats", r.mv ? 32'(r.len) << SECT_SHIFT : 32'h0, 32'(beats));
		chk("spin", {31'h0, r.sp}, {31'h0, spun});
		chk("activate", {31'h0, r.mv & r.cfg[0]}, {31'h0, actd});
		if (r.mv) chk("addr", {9'h0, r.off, 7'h0}, {9'h0, first_addr});
		if (r.mv) chk("last data", (32'(r.len) << SECT_SHIFT) - 32'h1, last_data);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'h0;
		rd(A_STATUS, s, q);
		chk("reset status", 32'h50, s);
		foreach (rows[k]) run(rows[k]);
		run(SEG0);
		run('{8'h93, 8'h03, 16'h1, 16'h3, 4'h0, 16'h0451, 1'h0, 1'h0});
		chk("offset discard", 32'h1, {31'h0, disc});
		run(SEG0);
		run(rows[8]);
		chk("command discard", 32'h1, {31'h0, disc});
		run(SEG0);
		disc = 1'h0;
		wr(A_CTRL, 32'h1, q);
		repeat (3) @(posedge clk);
		chk("reset discard", 32'h1, {31'h0, disc});
		rd(A_STATUS, s, q);
		chk("reset idle", 32'h50, {16'h0, s[15:0]});
		rd(5'h14, s, q);
		chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, q});
		complete_run();
	end
endmodule // test_disk_microcode_diag_flush_cmds
